/* File: core/seconds_counter_pkg.sv */
/*
  Constants shared by the seconds counter with alarm.
  Assumes a 20 MHz system clock and a 1 Hz tick from a separate time base.
*/
// How it works
// - Time is a 32-bit seconds count, advanced once per 1 Hz tick.
// - One comparator raises the alarm event when a tick steps the count to the alarm value.
// - Reset loads alarm with all ones; alarm then fires as the count steps to all ones, the tick before a wrap.
// - A seconds event is raised on every increment of the count.
// - A minute event fires on every sixtieth tick from reset unless a time write lands on that tick; time writes do not realign it to multiples of 60.
package seconds_counter_pkg;
  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          COUNT_WIDTH   = 32;
  localparam logic [31:0] COUNT_RESET   = 32'h0000_0000;
  localparam logic [31:0] ALARM_RESET   = 32'hffff_ffff;
  localparam logic [5:0]  MINUTE_LAST   = 6'h3b;
  localparam logic [5:0]  MINUTE_RESET  = 6'h00;
endpackage : seconds_counter_pkg

/* File: core/seconds_counter.sv */
/*
  Seconds counter with one alarm comparator and second/minute events.
  Assumes TICK_PIN is an asynchronous 1 Hz square wave from outside; the
  host writes time and alarm through plain write strobes on this clock.
*/
module seconds_counter
  import seconds_counter_pkg::*;
(
  input  wire logic                   CLOCK,
  input  wire logic                   NRST,
  input  wire logic                   TICK_PIN,
  input  wire logic                   TIME_WRITE,
  input  wire logic [COUNT_WIDTH-1:0] TIME_DATA,
  input  wire logic                   ALARM_WRITE,
  input  wire logic [COUNT_WIDTH-1:0] ALARM_DATA,
  input  wire logic                   ALARM_MASK,
  input  wire logic                   SECOND_MASK,
  input  wire logic                   MINUTE_MASK,
  output logic      [COUNT_WIDTH-1:0] TIME_VALUE,
  output logic      [COUNT_WIDTH-1:0] ALARM_VALUE,
  output logic                        ALARM_EVENT,
  output logic                        SECOND_EVENT,
  output logic                        MINUTE_EVENT
);

  // ----------------------------------------------------------------
  // Tick synchroniser and edge detect
  // ----------------------------------------------------------------
  logic       tick_meta;
  logic       tick_sync;
  logic       tick_last;
  logic       tick;
  logic [5:0] minute_phase;
  logic [COUNT_WIDTH-1:0] next_time;
  logic                   tick_take;
  logic                   minute_due;
  logic                   alarm_hit;
  logic [COUNT_WIDTH-1:0] match_bit;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      tick_meta <= 1'b0;
      tick_sync <= 1'b0;
      tick_last <= 1'b0;
    end else begin
      tick_meta <= TICK_PIN;
      tick_sync <= tick_meta;
      tick_last <= tick_sync;
    end
  end

  assign tick      = tick_sync & ~tick_last;
  assign next_time = TIME_VALUE + 32'h0000_0001;

  // ----------------------------------------------------------------
  // Accepted tick: a time write in the same cycle wins over the tick
  // ----------------------------------------------------------------
  assign tick_take = tick & ~TIME_WRITE;

  // ----------------------------------------------------------------
  // Minute boundary: the tick that closes the sixtieth second
  // ----------------------------------------------------------------
  assign minute_due = (minute_phase == MINUTE_LAST);

  // ----------------------------------------------------------------
  // Alarm comparator, one equality lane per count bit
  // ----------------------------------------------------------------
  genvar lane;
  generate
    for (lane = 0; lane < COUNT_WIDTH; lane++) begin : g_match
      assign match_bit[lane] = ~(next_time[lane] ^ ALARM_VALUE[lane]);
    end
  endgenerate

  assign alarm_hit = &match_bit;

  // ----------------------------------------------------------------
  // Seconds count
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      TIME_VALUE <= COUNT_RESET;
    end else if (TIME_WRITE) begin
      TIME_VALUE <= TIME_DATA;
    end else if (tick) begin
      TIME_VALUE <= next_time;
    end
  end

  // ----------------------------------------------------------------
  // Minute phase, free running, not touched by time writes
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      minute_phase <= MINUTE_RESET;
    end else if (tick) begin
      if (minute_phase == MINUTE_LAST) begin
        minute_phase <= MINUTE_RESET;
      end else begin
        minute_phase <= minute_phase + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm value
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ALARM_VALUE <= ALARM_RESET;
    end else if (ALARM_WRITE) begin
      ALARM_VALUE <= ALARM_DATA;
    end
  end

  // ----------------------------------------------------------------
  // Events, one cycle each, registered on the same edge that moves the count
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      SECOND_EVENT <= 1'b0;
    end else begin
      SECOND_EVENT <= tick_take & ~SECOND_MASK;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      MINUTE_EVENT <= 1'b0;
    end else begin
      MINUTE_EVENT <= tick_take & ~MINUTE_MASK & minute_due;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ALARM_EVENT <= 1'b0;
    end else begin
      ALARM_EVENT <= tick_take & ~ALARM_MASK & alarm_hit;
    end
  end

endmodule : seconds_counter

/* File: test/seconds_counter_assertions.sv */
/* Port checks for seconds_counter.
   Bound from the bench top file. */
module seconds_counter_assertions
  import seconds_counter_pkg::*;
(
  input wire logic                   CLOCK,
  input wire logic                   NRST,
  input wire logic [COUNT_WIDTH-1:0] TIME_VALUE,
  input wire logic [COUNT_WIDTH-1:0] ALARM_VALUE,
  input wire logic                   ALARM_EVENT,
  input wire logic                   SECOND_EVENT,
  input wire logic                   MINUTE_EVENT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  a_count_step: assert property (SECOND_EVENT |->
    TIME_VALUE == $past(TIME_VALUE) + 32'h1) else $error("count step");
  a_wrap_zero: assert property ($past(TIME_VALUE) == '1
    && SECOND_EVENT |-> TIME_VALUE == 32'h0) else $error("no wrap");
  a_alarm_match: assert property (ALARM_EVENT |->
    TIME_VALUE == $past(ALARM_VALUE)) else $error("alarm off value");
  a_alarm_reset: assert property ($rose(NRST) |->
    ALARM_VALUE == 32'hffff_ffff) else $error("alarm reset");
  a_second_pulse: assert property (SECOND_EVENT |=>
    !SECOND_EVENT) else $error("second pulse long");
  a_minute_align: assert property (MINUTE_EVENT |->
    TIME_VALUE % 60 == 0) else $error("minute unaligned");
endmodule : seconds_counter_assertions

/* File: test/test_seconds_counter.sv */
/* Bench for seconds_counter; inputs change at the falling edge.
   Masks held low except in t_mask. */
module test_seconds_counter import seconds_counter_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, nrst = 0, tick = 0, twr = 0, awr = 0, mask = 0;
  logic [31:0] tdata = 0, adata = 0, tval, aval;
  logic aev, sev, mev;
  int err_total = 0, compares = 0, nsec, nmin, nalm;
  seconds_counter i_dut (.CLOCK(clock), .NRST(nrst), .TICK_PIN(tick),
    .TIME_WRITE(twr), .TIME_DATA(tdata), .ALARM_WRITE(awr),
    .ALARM_DATA(adata), .ALARM_MASK(mask), .SECOND_MASK(mask),
    .MINUTE_MASK(mask), .TIME_VALUE(tval), .ALARM_VALUE(aval),
    .ALARM_EVENT(aev), .SECOND_EVENT(sev), .MINUTE_EVENT(mev));
  initial forever #25 clock = ~clock;
  always @(negedge clock) begin
    nsec += sev;
    nmin += mev;
    nalm += aev;
  end
  task automatic check(string what, logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic ticks(int n);
    repeat (n) begin
      tick = 1;
      repeat (4) @(negedge clock);
      tick = 0;
      repeat (2) @(negedge clock);
    end
  endtask : ticks
  task automatic t_minute();
    check("alarm", aval, 32'hffff_ffff);
    {nsec, nmin, nalm} = 0;
    ticks(60);
    check("time", tval, 32'd60);
    check("seconds", nsec, 60);
    check("minutes", nmin, 1);
    check("alarms", nalm, 0);
  endtask : t_minute
  task automatic t_alarm();
    {tdata, twr, adata, awr} = {32'hffff_ffff, 1'b1, 32'h1, 1'b1};
    @(negedge clock);
    {twr, awr} = 0;
    ticks(1);
    check("wrap", tval, 32'h0);
    check("alarms", nalm, 0);
    ticks(1);
    check("alarms", nalm, 1);
  endtask : t_alarm
  task automatic t_mask();
    int s;
    s = nsec;
    {mask, tdata, twr, adata, awr} = {1'b1, 32'd120, 1'b1, 32'd121, 1'b1};
    @(negedge clock);
    {twr, awr} = 0;
    check("time wr", tval, 32'd120);
    check("alarm wr", aval, 32'd121);
    ticks(1);
    check("time", tval, 32'd121);
    check("sec mask", nsec, s);
    check("alm mask", nalm, 1);
    mask = 0;
  endtask : t_mask
  task automatic give_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (8) @(negedge clock);
    nrst = 1;
    t_minute();
    t_alarm();
    t_mask();
    give_verdict();
  end
endmodule : test_seconds_counter
bind seconds_counter seconds_counter_assertions i_chk (.CLOCK, .NRST,
  .TIME_VALUE, .ALARM_VALUE, .ALARM_EVENT, .SECOND_EVENT, .MINUTE_EVENT);
